// ### logic/fir_param_rom.sv
// Read-only 256-byte discoverable parameter table, one byte per address.
// Purely combinational; the caller registers what it takes from it.
`timescale 1ns/1ps
module fir_param_rom (
  input wire logic [7:0] addr,
  output logic [7:0] data
);
  import fir_pkg::*;

  always_comb begin
    // [R5] Table lookup
    // [R15] Reserved ones
    data = 8'hFF;
    case (addr)
      // [R10] Signature bytes
      8'h00: data = 8'h53;
      8'h01: data = 8'h46;
      8'h02: data = 8'h44;
      8'h03: data = 8'h50;
      // [R11] Format revision
      8'h04: data = 8'h00;
      8'h05: data = 8'h01;
      // [R12] Header count
      8'h06: data = 8'h00;
      8'h07: data = 8'hFF;
      // [R13] First header
      8'h08: data = 8'h00;
      8'h09: data = 8'h00;
      8'h0A: data = 8'h01;
      8'h0B: data = 8'h09;
      // [R14] Table pointer
      8'h0C: data = 8'h80;
      8'h0D: data = 8'h00;
      8'h0E: data = 8'h00;
      // [R16] Erase and program
      8'h80: data = 8'hE5;
      // [R17] Small erase opcode
      8'h81: data = 8'h20;
      // [R18] Fast read support
      8'h82: data = 8'hF1;
      // [R19] Array density
      8'h84: data = 8'hFF;
      8'h85: data = 8'hFF;
      8'h86: data = 8'hFF;
      8'h87: data = 8'h00;
      // [R20] Quad io read
      8'h88: data = 8'h44;
      8'h89: data = 8'hEB;
      // [R21] Quad output read
      8'h8A: data = 8'h08;
      8'h8B: data = 8'h6B;
      // [R22] Dual output read
      8'h8C: data = 8'h08;
      8'h8D: data = 8'h3B;
      // [R23] Dual io read
      8'h8E: data = 8'h80;
      8'h8F: data = 8'hBB;
      // [R24] Four-line read
      8'h90: data = 8'hFE;
      // [R25] No dual-dual settings
      8'h96: data = 8'h00;
      default: data = 8'hFF;
    endcase
  end

endmodule

// ### logic/fir_pkg.sv
// Constants shared by the identification and parameter-table readout block.
// Assumes a single 10 MHz core clock; the serial link is sampled, not clocked.
package fir_pkg;

  // ------------------------------------------------------------
  // Command opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_READ_TABLE = 8'h5A;

  // ------------------------------------------------------------
  // Frame shape, counted in link clock rising edges
  // ------------------------------------------------------------
  localparam logic [5:0] OPCODE_CLKS_SINGLE = 6'h08;
  localparam logic [5:0] OPCODE_CLKS_QUAD = 6'h02;
  localparam logic [5:0] ADDR_CLKS = 6'h18;
  localparam logic [5:0] DUMMY_CLKS = 6'h08;
  localparam logic [5:0] CNT_RESET = 6'h00;

  // ------------------------------------------------------------
  // Output lane use and widths
  // ------------------------------------------------------------
  localparam int LANES = 4;
  localparam int SINGLE_OUT_LANE = 1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BITS_SINGLE = 4'h1;
  localparam logic [3:0] BITS_QUAD = 4'h4;
  localparam logic [1:0] ID_LAST_IDX = 2'h2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] LANE_RESET = 4'h0;

  typedef enum logic [2:0] {
    FIR_PH_CMD = 3'b000,
    FIR_PH_ADDR = 3'b001,
    FIR_PH_DUMMY = 3'b010,
    FIR_PH_OUT = 3'b011,
    FIR_PH_IGNORE = 3'b100
  } fir_phase_t;

  typedef enum logic {
    FIR_SRC_ID = 1'b0,
    FIR_SRC_TABLE = 1'b1
  } fir_src_t;

endpackage

// ### logic/fir_readout.sv
// Identification and parameter-table readout of a serial NOR flash.
// Assumes the host drives chip select, link clock and data asynchronously;
// all link pins are resynchronised to CLOCK, so the link clock must run
// well below a quarter of CLOCK.
//
// Summary of operation
// [R1] Identification opcode returns maker byte then two device bytes.
// [R2] Device bytes go out memory type first, then capacity.
// [R3] Identification bits change on link clock falling edges, MSB first.
// [R4] Identification works in single-line and four-line command modes.
// [R5] A 256-byte read-only parameter table is addressed byte by byte.
// [R6] Host sends table-read opcode, then 24 address bits on data in.
// [R7] Host keeps address bits 23..8 zero; bits 7..0 pick start byte.
// [R8] Eight dummy clocks follow; data starts on falling edge of clock 40.
// [R9] Further clocks return next table bytes, 8-bit address wraps.
// [R10] Bytes 00h..03h read 53h, 46h, 44h, 50h.
// [R11] Byte 04h reads 00h, byte 05h reads 01h.
// [R12] Byte 06h reads 00h, byte 07h reads FFh.
// [R13] Bytes 08h..0Bh read 00h, 00h, 01h, 09h.
// [R14] Bytes 0Ch..0Eh read 80h, 00h, 00h.
// [R15] Reserved bytes 0Fh..7Fh, 83h, 91h..95h read FFh.
// [R16] Byte 80h reads E5h.
// [R17] Byte 81h reads 20h.
// [R18] Byte 82h reads F1h.
// [R19] Bytes 84h..87h read FFh, FFh, FFh, 00h.
// [R20] Bytes 88h, 89h read 44h, EBh.
// [R21] Bytes 8Ah, 8Bh read 08h, 6Bh.
// [R22] Bytes 8Ch, 8Dh read 08h, 3Bh.
// [R23] Bytes 8Eh, 8Fh read 80h, BBh.
// [R24] Byte 90h reads FEh.
// [R25] Byte 96h reads 00h.
`timescale 1ns/1ps
module fir_readout #(
  // Arbitrary identification values, not those of any real part
  parameter logic [7:0] MAKER_ID = 8'h5C,
  parameter logic [7:0] MEMORY_TYPE = 8'h3E,
  parameter logic [7:0] CAPACITY = 8'h15
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CHIP_SELECT_N,
  input wire logic LINK_CLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic [2:0] DQ_UPPER_IN,
  input wire logic FOUR_LINE_COMMAND_MODE,
  output logic [3:0] DQ_OUT,
  output logic [3:0] DQ_OE,
  output logic BUSY
);
  import fir_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic [3:0] dq_s1;
    logic [3:0] dq_s2;
    fir_phase_t phase;
    fir_src_t src;
    logic quad;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [1:0] id_idx;
    logic [7:0] out_sh;
    logic [3:0] out_left;
    logic [3:0] dq_out;
    logic [3:0] dq_oe;
    logic busy;
  } fir_state_t;

  fir_state_t st_r;
  fir_state_t st_nxt;

  logic [7:0] rom_data;
  logic rise;
  logic fall;
  logic sel;
  logic [3:0] width;
  logic [7:0] cmd_new;
  logic [5:0] cnt_inc;
  logic [7:0] next_byte;
  logic [7:0] shifted;

  fir_param_rom u_rom (
    .addr(st_r.addr),
    .data(rom_data)
  );

  // ------------------------------------------------------------
  // Link edge detection
  // ------------------------------------------------------------
  // Edges come from the second and third stages only, so the first
  // stage never feeds logic and data lines line up with the edge.
  assign rise = st_r.ck_s2 & ~st_r.ck_s3;
  assign fall = ~st_r.ck_s2 & st_r.ck_s3;
  assign sel = ~st_r.cs_s2;
  assign width = st_r.quad ? BITS_QUAD : BITS_SINGLE;
  assign cnt_inc = st_r.cnt + 6'h01;

  always_comb begin
    cmd_new = {st_r.cmd[6:0], st_r.dq_s2[0]};
    // [R4] Nibble-wide opcode
    if (st_r.quad) begin
      cmd_new = {st_r.cmd[3:0], st_r.dq_s2};
    end
  end

  // ------------------------------------------------------------
  // Byte source for the output shifter
  // ------------------------------------------------------------
  always_comb begin
    next_byte = rom_data;
    if (st_r.src == FIR_SRC_ID) begin
      // [R2] Maker, type, capacity
      case (st_r.id_idx)
        2'h0: next_byte = MAKER_ID;
        2'h1: next_byte = MEMORY_TYPE;
        default: next_byte = CAPACITY;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic [5:0] op_clks;
  logic op_done;
  logic op_is_id;
  logic op_is_table;
  logic [1:0] id_next;

  // Opcode length follows the mode caught at the last deselect
  assign op_clks = st_r.quad ? OPCODE_CLKS_QUAD : OPCODE_CLKS_SINGLE;
  assign op_done = (cnt_inc == op_clks);
  assign op_is_id = (cmd_new == OP_READ_ID);
  // Table reads are single-line only; in four-line mode the frame is ignored
  assign op_is_table = (cmd_new == OP_READ_TABLE) && !st_r.quad;
  // Past the capacity byte the identification sequence starts over
  assign id_next = (st_r.id_idx == ID_LAST_IDX) ? 2'h0 : st_r.id_idx + 2'h1;

  // ------------------------------------------------------------
  // Output shifter
  // ------------------------------------------------------------
  // A byte is fetched only once the previous one is fully shifted out,
  // so the table address moves on exactly once per byte.
  logic load;
  logic [3:0] lane_bits;
  logic [3:0] lane_en;

  always_comb begin
    load = (st_r.out_left == LANE_RESET);
    shifted = st_r.out_sh;
    if (load) begin
      shifted = next_byte;
    end
  end

  // [R3] MSB first
  // [R4] Four-lane output
  // Unused lanes stay low in single-line mode
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    if (i == SINGLE_OUT_LANE) begin : g_single
      assign lane_bits[i] = st_r.quad ? shifted[LANES + i] : shifted[7];
      assign lane_en[i] = 1'b1;
    end else begin : g_quad
      assign lane_bits[i] = st_r.quad & shifted[LANES + i];
      assign lane_en[i] = st_r.quad;
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_s1 = CHIP_SELECT_N;
    st_nxt.cs_s2 = st_r.cs_s1;
    st_nxt.ck_s1 = LINK_CLK;
    st_nxt.ck_s2 = st_r.ck_s1;
    st_nxt.ck_s3 = st_r.ck_s2;
    st_nxt.dq_s1 = {DQ_UPPER_IN, SERIAL_DATA_IN};
    st_nxt.dq_s2 = st_r.dq_s1;

    if (!sel) begin
      // Deselected: release the lines and arm for the next frame.
      // The mode is caught here so it cannot change mid-frame.
      st_nxt.phase = FIR_PH_CMD;
      st_nxt.cnt = CNT_RESET;
      st_nxt.out_left = LANE_RESET;
      st_nxt.id_idx = 2'h0;
      st_nxt.dq_oe = LANE_RESET;
      st_nxt.dq_out = LANE_RESET;
      st_nxt.quad = FOUR_LINE_COMMAND_MODE;
    end else if (rise) begin
      case (st_r.phase)
        FIR_PH_CMD: begin
          st_nxt.cmd = cmd_new;
          st_nxt.cnt = cnt_inc;
          if (op_done) begin
            st_nxt.cnt = CNT_RESET;
            st_nxt.phase = FIR_PH_IGNORE;
            // [R1] Identification opcode
            // [R4] Either command mode
            if (op_is_id) begin
              st_nxt.phase = FIR_PH_OUT;
              st_nxt.src = FIR_SRC_ID;
            end else if (op_is_table) begin
              st_nxt.phase = FIR_PH_ADDR;
              st_nxt.src = FIR_SRC_TABLE;
            end
          end
        end
        FIR_PH_ADDR: begin
          // [R6] Serial address bits
          // [R7] Only low byte kept
          st_nxt.addr = {st_r.addr[6:0], st_r.dq_s2[0]};
          st_nxt.cnt = cnt_inc;
          if (cnt_inc == ADDR_CLKS) begin
            st_nxt.cnt = CNT_RESET;
            st_nxt.phase = FIR_PH_DUMMY;
          end
        end
        FIR_PH_DUMMY: begin
          // [R8] Eight dummy clocks
          st_nxt.cnt = cnt_inc;
          if (cnt_inc == DUMMY_CLKS) begin
            st_nxt.cnt = CNT_RESET;
            st_nxt.phase = FIR_PH_OUT;
          end
        end
        FIR_PH_OUT: begin
          st_nxt.cnt = st_r.cnt;
        end
        FIR_PH_IGNORE: begin
          st_nxt.cnt = st_r.cnt;
        end
        default: begin
          st_nxt.phase = FIR_PH_IGNORE;
        end
      endcase
    end else if (fall && st_r.phase == FIR_PH_OUT) begin
      // [R3] Falling-edge launch
      // [R8] First data on clock 40
      if (load) begin
        st_nxt.out_left = BITS_PER_BYTE - width;
        if (st_r.src == FIR_SRC_ID) begin
          st_nxt.id_idx = id_next;
        end else begin
          // [R9] Address wraps at 8 bits
          st_nxt.addr = st_r.addr + 8'h01;
        end
      end else begin
        st_nxt.out_left = st_r.out_left - width;
      end
      st_nxt.dq_out = lane_bits;
      st_nxt.dq_oe = lane_en;
      st_nxt.out_sh = st_r.quad ? {shifted[3:0], 4'h0} : {shifted[6:0], 1'b0};
    end
    // Busy follows the enables registered in the same cycle
    st_nxt.busy = (st_nxt.dq_oe != LANE_RESET);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Reset leaves the link seen as idle, clock low and chip select high,
  // so no false edge or frame start follows the release.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r.cs_s1 <= 1'b1;
      st_r.cs_s2 <= 1'b1;
      st_r.ck_s1 <= 1'b0;
      st_r.ck_s2 <= 1'b0;
      st_r.ck_s3 <= 1'b0;
      st_r.dq_s1 <= LANE_RESET;
      st_r.dq_s2 <= LANE_RESET;
      st_r.phase <= FIR_PH_CMD;
      st_r.src <= FIR_SRC_ID;
      st_r.quad <= 1'b0;
      st_r.cnt <= CNT_RESET;
      st_r.cmd <= BYTE_RESET;
      st_r.addr <= BYTE_RESET;
      st_r.id_idx <= 2'h0;
      st_r.out_sh <= BYTE_RESET;
      st_r.out_left <= LANE_RESET;
      st_r.dq_out <= LANE_RESET;
      st_r.dq_oe <= LANE_RESET;
      st_r.busy <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign DQ_OUT = st_r.dq_out;
  assign DQ_OE = st_r.dq_oe;
  assign BUSY = st_r.busy;

endmodule

// ### sim/fir_host.sv
// Host model: drives chip select, link clock and data lanes of the readout block.
// Assumes a core clock; link clock is 4 core cycles low and 4 high.
`timescale 1ns/1ps
module fir_host (
  input wire logic clock,
  output logic cs_n,
  output logic link_clk,
  output logic data0,
  output logic [2:0] data_upper,
  output logic four_line,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe
);
  logic [3:0] q;
  logic [3:0] oe_or;
  logic [7:0] rxq[$];

  initial begin
    cs_n = 1'b1;
    link_clk = 1'b0;
    data0 = 1'b0;
    data_upper = 3'h0;
    four_line = 1'b0;
  end

  // ------------------------------------------------------------
  // Link cycles
  // ------------------------------------------------------------
  // Sample mid high phase: output launched at the fall has long settled
  task automatic bit_cyc(input logic [3:0] d);
    @(posedge clock);
    link_clk <= 1'b0;
    {data_upper, data0} <= d;
    repeat (4) @(posedge clock);
    link_clk <= 1'b1;
    repeat (2) @(posedge clock);
    q = dq_out;
    oe_or = oe_or | dq_oe;
    @(posedge clock);
  endtask

  // Opcode, zero-topped address, dummy clocks, then read bytes
  task automatic frame(input logic quad, input logic [7:0] op, input logic [31:0] ad, input int nad, input int nb);
    logic [7:0] b;
    rxq = {};
    oe_or = 4'h0;
    @(posedge clock);
    four_line <= quad;
    repeat (3) @(posedge clock);
    cs_n <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < (quad ? 2 : 8); i++) bit_cyc(quad ? op[7 - 4 * i -: 4] : {3'($urandom), op[7 - i]});
    for (int i = 0; i < nad; i++) bit_cyc({3'($urandom), ad[31 - i]});
    for (int n = 0; n < nb; n++) begin
      for (int i = 0; i < (quad ? 2 : 8); i++) begin
        bit_cyc(4'($urandom));
        b = quad ? {b[3:0], q} : {b[6:0], q[1]};
      end
      rxq.push_back(b);
    end
    @(posedge clock);
    cs_n <= 1'b1;
    repeat (4) @(posedge clock);
    link_clk <= 1'b0;
    data0 <= ~data0;
  endtask
endmodule

// ### sim/fir_readout_asserts.sv
// Checker for the readout block, watching only its top-level ports.
// Assumes one core clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module fir_readout_chk (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CHIP_SELECT_N,
  input wire logic LINK_CLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic [2:0] DQ_UPPER_IN,
  input wire logic FOUR_LINE_COMMAND_MODE,
  input wire logic [3:0] DQ_OUT,
  input wire logic [3:0] DQ_OE,
  input wire logic BUSY
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  // ------------------------------------------------------------
  // Output timing
  // ------------------------------------------------------------
  a_oe_lanes: assert property ((|DQ_OE) |-> DQ_OE == (FOUR_LINE_COMMAND_MODE ? 4'hF : 4'h2))
    else $error("wrong output enable lanes");
  a_idle_quiet: assert property (CHIP_SELECT_N [*5] |-> DQ_OE == 4'h0)
    else $error("driving while deselected");
  a_busy_set: assert property ((|DQ_OE) |-> BUSY)
    else $error("busy missing while driving");
  a_busy_clear: assert property (!(|DQ_OE) |-> !BUSY)
    else $error("busy stuck while idle");
  a_out_steady: assert property ((LINK_CLK && !CHIP_SELECT_N) [*4] |-> $stable(DQ_OUT))
    else $error("data changed in link high phase");
  a_oe_on_fall: assert property ($rose(|DQ_OE) |-> !$past(LINK_CLK, 2))
    else $error("output started away from a fall");
  a_oe_drop_cs: assert property ($fell(|DQ_OE) |-> $past(CHIP_SELECT_N, 2))
    else $error("output released while selected");
  a_oe_after_cmd: assert property ($rose(|DQ_OE) |-> !$past(CHIP_SELECT_N, 16))
    else $error("output started before a whole opcode");

  cover property ($rose(DQ_OE == 4'h2));
  cover property ($rose(DQ_OE == 4'hF));
  cover property ($fell(|DQ_OE));
endmodule

bind fir_readout fir_readout_chk u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CHIP_SELECT_N(CHIP_SELECT_N),
  .LINK_CLK(LINK_CLK), .SERIAL_DATA_IN(SERIAL_DATA_IN), .DQ_UPPER_IN(DQ_UPPER_IN),
  .FOUR_LINE_COMMAND_MODE(FOUR_LINE_COMMAND_MODE), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .BUSY(BUSY));

// ### sim/tb_top.sv
// Self-checking bench for the identification and parameter-table readout.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_top;
  import fir_pkg::*;
  // Arbitrary identification values: maker, memory type, capacity
  localparam logic [23:0] IDV = 24'h6D4217;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cs_n, lclk, d0, quad, busy;
  logic [2:0] dup;
  logic [3:0] dq_out, dq_oe;
  logic [7:0] st, op;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;

  always #50 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  fir_readout #(.MAKER_ID(IDV[23:16]), .MEMORY_TYPE(IDV[15:8]), .CAPACITY(IDV[7:0])) dut (
    .CLOCK(clock), .SYS_RST(sys_rst), .CHIP_SELECT_N(cs_n), .LINK_CLK(lclk), .SERIAL_DATA_IN(d0),
    .DQ_UPPER_IN(dup), .FOUR_LINE_COMMAND_MODE(quad), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .BUSY(busy));
  fir_host host (.clock(clock), .cs_n(cs_n), .link_clk(lclk), .data0(d0), .data_upper(dup),
    .four_line(quad), .dq_out(dq_out), .dq_oe(dq_oe));

  // ------------------------------------------------------------
  // Expectations and reporting
  // ------------------------------------------------------------
  // Table image
  function automatic logic [7:0] exp_tbl(input logic [7:0] a);
    case (a)
      8'h00: return 8'h53;
      8'h01: return 8'h46;
      8'h02, 8'h88: return 8'h44;
      8'h03: return 8'h50;
      8'h05, 8'h0A: return 8'h01;
      8'h0B: return 8'h09;
      8'h0C, 8'h8E: return 8'h80;
      8'h04, 8'h06, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h87, 8'h96: return 8'h00;
      8'h80: return 8'hE5;
      8'h81: return 8'h20;
      8'h82: return 8'hF1;
      8'h89: return 8'hEB;
      8'h8A, 8'h8C: return 8'h08;
      8'h8B: return 8'h6B;
      8'h8D: return 8'h3B;
      8'h8F: return 8'hBB;
      8'h90: return 8'hFE;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hCFA2BD9A));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    host.frame(1'b0, OP_READ_ID, 32'h0, 0, 7);
    for (int i = 0; i < 7; i++) chk("id byte", IDV[23 - 8 * (i % 3) -: 8], host.rxq[i]);
    chk("id lanes", 8'h02, {4'h0, host.oe_or});
    $display("test id_single done");
    host.frame(1'b1, OP_READ_ID, 32'h0, 0, 4);
    for (int i = 0; i < 4; i++) chk("quad id byte", IDV[23 - 8 * (i % 3) -: 8], host.rxq[i]);
    chk("quad id lanes", 8'h0F, {4'h0, host.oe_or});
    $display("test id_quad done");
    // Long read from a random start crosses the wrap; a short one starts on it
    st = 8'($urandom);
    for (int t = 0; t < 2; t++) begin
      host.frame(1'b0, OP_READ_TABLE, {16'h0000, st, 8'($urandom)}, 32, t ? 3 : 260);
      for (int i = 0; i < host.rxq.size(); i++) begin
        chk("table byte", exp_tbl(st + 8'(i)), host.rxq[i]);
      end
      st = 8'hFF;
    end
    $display("test table done");
    host.frame(1'b1, OP_READ_TABLE, 32'h0, 0, 2);
    chk("quad table lanes", 8'h00, {4'h0, host.oe_or});
    for (int t = 0; t < 3; t++) begin
      op = 8'($urandom);
      if (op == OP_READ_ID || op == OP_READ_TABLE) op = 8'h00;
      host.frame(1'b0, op, 32'h0, 0, 1);
      chk("unknown op lanes", 8'h00, {4'h0, host.oe_or});
    end
    $display("test refused done");
    end_of_test();
  end
endmodule
